// *** src/limit_alarm_pkg.sv ***
// shared constants of the process limit alarm monitor: parameter indices,
// record sub-indices, field positions, priority grades and reset values.
// assumes limits, hysteresis and process result are signed 32-bit integers.
`default_nettype none
package limit_alarm_pkg;
   localparam int NUM_LIMITS = 4;
   // limit channels, in this order everywhere
   localparam int CH_UPPER_ALARM   = 0;
   localparam int CH_UPPER_WARNING = 1;
   localparam int CH_LOWER_WARNING = 2;
   localparam int CH_LOWER_ALARM   = 3;

   // parameter indices
   localparam logic [7:0] IDX_ACK_OPTION              = 8'h17;
   localparam logic [7:0] IDX_ALARM_HYSTERESIS        = 8'h18;
   localparam logic [7:0] IDX_UPPER_ALARM_PRIORITY    = 8'h19;
   localparam logic [7:0] IDX_UPPER_ALARM_THRESHOLD   = 8'h1a;
   localparam logic [7:0] IDX_UPPER_WARNING_PRIORITY  = 8'h1b;
   localparam logic [7:0] IDX_UPPER_WARNING_THRESHOLD = 8'h1c;
   localparam logic [7:0] IDX_LOWER_WARNING_PRIORITY  = 8'h1d;
   localparam logic [7:0] IDX_LOWER_WARNING_THRESHOLD = 8'h1e;
   localparam logic [7:0] IDX_LOWER_ALARM_PRIORITY    = 8'h1f;
   localparam logic [7:0] IDX_LOWER_ALARM_THRESHOLD   = 8'h20;
   localparam logic [7:0] IDX_UPPER_ALARM_RECORD      = 8'h21;
   localparam logic [7:0] IDX_UPPER_WARNING_RECORD    = 8'h22;
   localparam logic [7:0] IDX_LOWER_WARNING_RECORD    = 8'h23;
   localparam logic [7:0] IDX_LOWER_ALARM_RECORD      = 8'h24;

   // per channel index tables, element i belongs to channel i
   localparam logic [3:0][7:0] LIM_IDX = {IDX_LOWER_ALARM_THRESHOLD,
      IDX_LOWER_WARNING_THRESHOLD, IDX_UPPER_WARNING_THRESHOLD,
      IDX_UPPER_ALARM_THRESHOLD};
   localparam logic [3:0][7:0] PRI_IDX = {IDX_LOWER_ALARM_PRIORITY,
      IDX_LOWER_WARNING_PRIORITY, IDX_UPPER_WARNING_PRIORITY,
      IDX_UPPER_ALARM_PRIORITY};
   localparam logic [3:0][7:0] REC_IDX = {IDX_LOWER_ALARM_RECORD,
      IDX_LOWER_WARNING_RECORD, IDX_UPPER_WARNING_RECORD,
      IDX_UPPER_ALARM_RECORD};
   // automatic acknowledgement option bit of each channel
   localparam logic [3:0][2:0] ACKOPT_POS = {3'h4, 3'h5, 3'h3, 3'h2};

   // record sub-indices
   localparam logic [1:0] SUB_STATUS = 2'h0;
   localparam logic [1:0] SUB_TIME   = 2'h1;
   localparam logic [1:0] SUB_VALUE  = 2'h2;

   // record status byte fields
   localparam int ST_ACTIVE   = 0;
   localparam int ST_UNACKED  = 1;
   localparam int ST_NOTICE   = 2;
   localparam int ST_CRITICAL = 3;
   localparam int ACK_WR_BIT  = 0;

   // priority grades
   localparam logic [3:0] PRI_OFF        = 4'h0;
   localparam logic [3:0] PRI_SILENT     = 4'h1;
   localparam logic [3:0] PRI_RESERVED   = 4'h2;
   localparam logic [3:0] PRI_NOTICE_MIN = 4'h3;
   localparam logic [3:0] PRI_NOTICE_MAX = 4'h7;
   localparam logic [3:0] PRI_CRIT_MIN   = 4'h8;
   localparam logic [3:0] PRI_CRIT_MAX   = 4'hf;

   // values after reset
   localparam logic [31:0] RST_UPPER_LIMIT = 32'h7fffffff;
   localparam logic [31:0] RST_LOWER_LIMIT = 32'h80000000;
   localparam logic [31:0] RST_HYSTERESIS  = 32'h00000000;
   localparam logic [3:0]  RST_PRIORITY    = 4'h0;
   localparam logic [7:0]  RST_ACK_OPTION  = 8'h00;

   // cycles from a parameter request to its answer
   localparam int ANSWER_CYCLES = 1;
endpackage
`default_nettype wire

// *** src/limit_channel.sv ***
// one limit comparator with hysteresis and its alarm record.
// assumes evalStb and ackStb are one-cycle strobes on ref_clk.
`timescale 1ns/10ps
`default_nettype none
module limit_channel
   import limit_alarm_pkg::*;
#(
   parameter bit UPPER = 1'b1
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        evalStb,
   input  wire logic [31:0] procValue,
   input  wire logic [31:0] limitValue,
   input  wire logic [31:0] hysteresis,
   input  wire logic [3:0]  priCode,
   input  wire logic        autoAck,
   input  wire logic        ackStb,
   input  wire logic [31:0] timeNow,
   output logic             active,
   output logic             unacked,
   output logic [31:0]      alarmTime,
   output logic [31:0]      trigValue,
   output logic             alertPulse,
   output logic             alertCritical
);
   typedef struct packed {
      logic        active;
      logic        unack;
      logic [31:0] tim;
      logic [31:0] val;
      logic        pulse;
      logic        crit;
   } chan_t;

   chan_t              s_q;
   chan_t              s_d;
   logic signed [33:0] v;
   logic signed [33:0] l;
   logic signed [33:0] h;
   logic               violate;
   logic               released;
   logic               raise;

   always_comb begin
      v        = 34'(signed'(procValue));
      l        = 34'(signed'(limitValue));
      h        = 34'(signed'(hysteresis));
      violate  = UPPER ? (v > l) : (v < l);
      released = UPPER ? (v < l - h) : (v > l + h);
      raise    = evalStb && (priCode != PRI_OFF) && !s_q.active && violate;
      s_d       = s_q;
      s_d.pulse = 1'b0;
      s_d.crit  = 1'b0;
      if (ackStb) begin
         s_d.unack = 1'b0;
      end
      if (priCode == PRI_OFF) begin
         s_d.active = 1'b0;
      end else if (raise) begin
         s_d.active = 1'b1;
         s_d.tim    = timeNow;
         s_d.val    = procValue;
         // a raise in the ack cycle wins; auto option never leaves it open
         s_d.unack  = !autoAck;
         s_d.pulse  = (priCode >= PRI_NOTICE_MIN);
         s_d.crit   = (priCode >= PRI_CRIT_MIN);
      end else if (evalStb && s_q.active && released) begin
         s_d.active = 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign active        = s_q.active;
   assign unacked       = s_q.unack;
   assign alarmTime     = s_q.tim;
   assign trigValue     = s_q.val;
   assign alertPulse    = s_q.pulse;
   assign alertCritical = s_q.crit;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_off_never_active: assert property (
      priCode == PRI_OFF |=> !active)
      else $error("alarm active while its limit is switched off");
   a_silent_no_alert: assert property (
      raise && priCode < PRI_NOTICE_MIN |=> active && !alertPulse)
      else $error("silent priority produced an alert");
   a_notice_grade: assert property (
      raise && priCode >= PRI_NOTICE_MIN && priCode <= PRI_NOTICE_MAX
      |=> alertPulse && !alertCritical)
      else $error("notice grade not reported as a notice");
   a_critical_grade: assert property (
      raise && priCode >= PRI_CRIT_MIN |=> alertPulse && alertCritical)
      else $error("critical grade not reported as critical");
   a_record_capture: assert property (
      raise |=> alarmTime == $past(timeNow) && trigValue == $past(procValue))
      else $error("alarm record did not capture time and value");
   a_auto_ack: assert property (
      raise && autoAck |=> active && !unacked)
      else $error("auto acknowledged alarm left unacknowledged");
   a_hyst_hold: assert property (
      active && evalStb && !released && priCode != PRI_OFF |=> active)
      else $error("alarm dropped inside hysteresis band");
   a_release_keeps_ack: assert property (
      active && unacked && evalStb && released && !ackStb
      && priCode != PRI_OFF |=> !active && unacked)
      else $error("release did not clear active or lost ack state");
endmodule
`default_nettype wire

// *** src/process_limit_alarm_monitor.sv ***
// limit alarm stage: four limit channels, their priorities, hysteresis,
// auto acknowledgement option and alarm records behind a parameter port.
// assumes procValue, timeNow and the parameter port come from logic on
// ref_clk, so none of them is synchronised here.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - upper alarm when result exceeds its threshold
// - upper warning when result exceeds its threshold
// - lower warning when result drops below threshold
// - lower alarm when result drops below threshold
// - independent priority code for each limit
// - priority zero disables evaluation of limit
// - priority one evaluates without any notification
// - priorities three to seven give user notice
// - priorities eight to fifteen give critical alarm
// - each record holds state, time, value
// - host acknowledges by writing record, rest read-only
// - auto option acknowledges alarm at recognition
// - alarm stays active within hysteresis band
// - upper alarm has its own priority grading
module process_limit_alarm_monitor
   import limit_alarm_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic [31:0] procValue,
   input  wire logic        procValid,
   input  wire logic [31:0] timeNow,
   input  wire logic        parWrite,
   input  wire logic        parRead,
   input  wire logic [7:0]  parIndex,
   input  wire logic [1:0]  parSub,
   input  wire logic [31:0] parWdata,
   output logic [31:0]      parRdata,
   output logic             parDone,
   output logic             parError,
   output logic [3:0]       alarmActive,
   output logic [3:0]       alarmUnacked,
   output logic [3:0]       alertPulse,
   output logic [3:0]       alertCritical
);
   typedef struct packed {
      logic [3:0][31:0] lim;
      logic [3:0][3:0]  pri;
      logic [31:0]      hyst;
      logic [7:0]       ackOpt;
      logic [31:0]      rdata;
      logic             done;
      logic             err;
   } mon_t;

   localparam mon_t MON_RESET = '{
      lim:    {RST_LOWER_LIMIT, RST_LOWER_LIMIT,
               RST_UPPER_LIMIT, RST_UPPER_LIMIT},
      pri:    {RST_PRIORITY, RST_PRIORITY, RST_PRIORITY, RST_PRIORITY},
      hyst:   RST_HYSTERESIS,
      ackOpt: RST_ACK_OPTION,
      rdata:  32'h00000000,
      done:   1'b0,
      err:    1'b0
   };

   mon_t             s_q;
   mon_t             s_d;
   logic             hit;
   logic [3:0]       chActive;
   logic [3:0]       chUnacked;
   logic [3:0][31:0] chTime;
   logic [3:0][31:0] chValue;
   logic [3:0]       chPulse;
   logic [3:0]       chCrit;
   logic [3:0]       ackStb;
   logic [3:0][3:0]  statusBits;

   // parameter access: one request per cycle, answered on the next edge
   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      s_d.err  = 1'b0;
      hit      = 1'b0;
      if (parRead || parWrite) begin
         s_d.done  = 1'b1;
         s_d.rdata = 32'h00000000;
         if (parIndex == IDX_ACK_OPTION) begin
            hit       = 1'b1;
            s_d.rdata = {24'h000000, s_q.ackOpt};
            if (parWrite) begin
               s_d.ackOpt = parWdata[7:0];
            end
         end
         if (parIndex == IDX_ALARM_HYSTERESIS) begin
            hit       = 1'b1;
            s_d.rdata = s_q.hyst;
            if (parWrite) begin
               s_d.hyst = parWdata;
            end
         end
         for (int i = 0; i < NUM_LIMITS; i++) begin
            if (parIndex == LIM_IDX[i]) begin
               hit       = 1'b1;
               s_d.rdata = s_q.lim[i];
               if (parWrite) begin
                  s_d.lim[i] = parWdata;
               end
            end
            if (parIndex == PRI_IDX[i]) begin
               hit       = 1'b1;
               s_d.rdata = {28'h0000000, s_q.pri[i]};
               if (parWrite) begin
                  s_d.pri[i] = parWdata[3:0];
               end
            end
            if (parIndex == REC_IDX[i]) begin
               hit = 1'b1;
               case (parSub)
                  SUB_STATUS: begin
                     s_d.rdata = {28'h0000000, statusBits[i]};
                  end
                  SUB_TIME: begin
                     s_d.rdata = chTime[i];
                     s_d.err   = parWrite;
                  end
                  SUB_VALUE: begin
                     s_d.rdata = chValue[i];
                     s_d.err   = parWrite;
                  end
                  default: begin
                     s_d.err = 1'b1;
                  end
               endcase
            end
         end
         if (!hit) begin
            s_d.err = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= MON_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_LIMITS; g++) begin : gLimit
         // only a write of the status byte with the ack bit acknowledges
         assign ackStb[g] = parWrite && parIndex == REC_IDX[g]
            && parSub == SUB_STATUS && parWdata[ACK_WR_BIT];

         assign statusBits[g][ST_ACTIVE]   = chActive[g];
         assign statusBits[g][ST_UNACKED]  = chUnacked[g];
         assign statusBits[g][ST_NOTICE]   = s_q.pri[g] >= PRI_NOTICE_MIN;
         assign statusBits[g][ST_CRITICAL] = s_q.pri[g] >= PRI_CRIT_MIN;

         limit_channel #(
            .UPPER (g < 2)
         ) uChannel (
            .ref_clk       (ref_clk),
            .rst_n         (rst_n),
            .evalStb       (procValid),
            .procValue     (procValue),
            .limitValue    (s_q.lim[g]),
            .hysteresis    (s_q.hyst),
            .priCode       (s_q.pri[g]),
            .autoAck       (s_q.ackOpt[ACKOPT_POS[g]]),
            .ackStb        (ackStb[g]),
            .timeNow       (timeNow),
            .active        (chActive[g]),
            .unacked       (chUnacked[g]),
            .alarmTime     (chTime[g]),
            .trigValue     (chValue[g]),
            .alertPulse    (chPulse[g]),
            .alertCritical (chCrit[g])
         );
      end
   endgenerate

   assign parRdata      = s_q.rdata;
   assign parDone       = s_q.done;
   assign parError      = s_q.err;
   assign alarmActive   = chActive;
   assign alarmUnacked  = chUnacked;
   assign alertPulse    = chPulse;
   assign alertCritical = chCrit;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   sequence evalRise(int ch, bit up);
      procValid && s_q.pri[ch] != PRI_OFF && !chActive[ch]
      && (up ? $signed(procValue) > $signed(s_q.lim[ch])
             : $signed(procValue) < $signed(s_q.lim[ch]));
   endsequence

   sequence priWrite(int ch);
      parWrite && parIndex == PRI_IDX[ch];
   endsequence

   sequence priReadBack(int ch);
      parRead && parIndex == PRI_IDX[ch] && !parWrite;
   endsequence

   a_upper_alarm_rise: assert property (
      evalRise(CH_UPPER_ALARM, 1'b1) |=> alarmActive[CH_UPPER_ALARM])
      else $error("upper alarm not raised above threshold");
   a_upper_warn_rise: assert property (
      evalRise(CH_UPPER_WARNING, 1'b1) |=> alarmActive[CH_UPPER_WARNING])
      else $error("upper warning not raised above threshold");
   a_lower_warn_rise: assert property (
      evalRise(CH_LOWER_WARNING, 1'b0) |=> alarmActive[CH_LOWER_WARNING])
      else $error("lower warning not raised below threshold");
   a_lower_alarm_rise: assert property (
      evalRise(CH_LOWER_ALARM, 1'b0) |=> alarmActive[CH_LOWER_ALARM])
      else $error("lower alarm not raised below threshold");
   a_priority_independent: assert property (
      priWrite(CH_UPPER_WARNING) ##1 priReadBack(CH_LOWER_WARNING)
      |=> parRdata[3:0] == $past(s_q.pri[CH_LOWER_WARNING]))
      else $error("priority write leaked into another limit");
   a_upper_alarm_priority: assert property (
      priWrite(CH_UPPER_ALARM) ##1 priReadBack(CH_UPPER_ALARM)
      |=> parRdata == {28'h0000000, $past(parWdata[3:0], 2)})
      else $error("upper alarm priority not held as four bits");
   a_ack_clears: assert property (
      ackStb[CH_LOWER_ALARM] && !procValid |=> !alarmUnacked[CH_LOWER_ALARM])
      else $error("record acknowledge did not clear unacknowledged");
   a_record_readonly: assert property (
      parWrite && parIndex == IDX_UPPER_ALARM_RECORD
      && (parSub == SUB_TIME || parSub == SUB_VALUE)
      |=> parDone && parError)
      else $error("write to read-only record part not refused");
   a_answer_once: assert property (
      (parRead || parWrite) |=> parDone ##1 (parDone == $past(parRead
      || parWrite)))
      else $error("parameter answer not one cycle after request");
endmodule
`default_nettype wire

// *** sim/fieldbus_host.sv ***
// host model: one parameter request per call, or a write and a read
// issued back to back.
// assumes parDone answers on the taking edge, seen at the next falling edge.
`timescale 1ns/10ps
`default_nettype none
module fieldbus_host
   import limit_alarm_pkg::*;
(
   input  wire logic        ref_clk,
   output logic             parWrite,
   output logic             parRead,
   output logic [7:0]       parIndex,
   output logic [1:0]       parSub,
   output logic [31:0]      parWdata,
   input  wire logic [31:0] parRdata,
   input  wire logic        parDone,
   input  wire logic        parError
);
   initial begin
      parWrite = 1'b0;
      parRead  = 1'b0;
      parIndex = 8'h00;
      parSub   = 2'h0;
      parWdata = 32'h0;
   end

   // ok stays low when no answer arrives within the bound
   task automatic access(input bit wr, input logic [7:0] idx,
                         input logic [1:0] sub, input logic [31:0] wd,
                         output logic [31:0] rd, output logic err,
                         output bit ok);
      ok  = 1'b0;
      rd  = 32'h0;
      err = 1'b1;
      @(negedge ref_clk);
      parWrite = wr;
      parRead  = !wr;
      parIndex = idx;
      parSub   = sub;
      parWdata = wd;
      @(negedge ref_clk);
      parWrite = 1'b0;
      parRead  = 1'b0;
      // released index and data lines carry the complement, not a stale value
      parIndex = ~idx;
      parWdata = ~wd;
      for (int i = 0; i < 4 && !ok; i++) begin
         if (parDone === 1'b1) begin
            ok  = 1'b1;
            rd  = parRdata;
            err = parError;
         end else
            @(negedge ref_clk);
      end
   endtask

   // write on one edge, read on the very next, the read answer returned
   task automatic write_read(input logic [7:0] wIdx, input logic [31:0] wd,
                             input logic [7:0] rIdx,
                             output logic [31:0] rd, output logic err,
                             output bit ok);
      @(negedge ref_clk);
      parWrite = 1'b1;
      parRead  = 1'b0;
      parIndex = wIdx;
      parSub   = SUB_STATUS;
      parWdata = wd;
      access(1'b0, rIdx, SUB_STATUS, 32'h0, rd, err, ok);
   endtask

   // acknowledge by setting bit 0 of the record status
   task automatic acknowledge(input int ch, output logic err, output bit ok);
      logic [31:0] rd;
      access(1'b1, REC_IDX[ch], SUB_STATUS, 32'h1, rd, err, ok);
   endtask
endmodule
`default_nettype wire

// *** sim/test_process_limit_alarm_monitor.sv ***
// self-checking bench: reset values, records, hysteresis corners and a
// seeded random run checked against a behavioural expectation.
// assumes the fieldbus_host model drives the parameter port.
`timescale 1ns/10ps
`default_nettype none
module test_process_limit_alarm_monitor
   import limit_alarm_pkg::*;
();
   logic        ref_clk, rst_n, procValid, parWrite, parRead;
   logic        parDone, parError;
   logic [31:0] procValue, timeNow, parWdata, parRdata, hyst, lfsr;
   logic [7:0]  parIndex, ackOpt;
   logic [1:0]  parSub;
   logic [3:0]  alarmActive, alarmUnacked, alertPulse, alertCritical;
   logic [3:0]  eAct, eUnack;
   logic [3:0]  pri[4];
   logic [31:0] lim[4], eTime[4], eVal[4];
   int          mismatches, n_tests;

   process_limit_alarm_monitor u_process_limit_alarm_monitor (.ref_clk,
      .rst_n, .procValue, .procValid, .timeNow, .parWrite, .parRead,
      .parIndex, .parSub, .parWdata, .parRdata, .parDone, .parError,
      .alarmActive, .alarmUnacked, .alertPulse, .alertCritical);
   fieldbus_host u_fieldbus_host (.ref_clk, .parWrite, .parRead, .parIndex,
      .parSub, .parWdata, .parRdata, .parDone, .parError);

   always #2 ref_clk = ~ref_clk;

   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   function automatic logic signed [33:0] sx(logic [31:0] x);
      return $signed({{2{x[31]}}, x});
   endfunction
   function automatic bit beyond(int ch, logic [31:0] v);
      if (ch < 2)
         return sx(v) > sx(lim[ch]);
      return sx(v) < sx(lim[ch]);
   endfunction
   function automatic bit backIn(int ch, logic [31:0] v);
      if (ch < 2)
         return sx(v) < sx(lim[ch]) - sx(hyst);
      return sx(v) > sx(lim[ch]) + sx(hyst);
   endfunction

   task automatic stop_test();
      $display("mismatches %0d comparisons %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic par(input bit wr, input logic [7:0] idx,
                      input logic [1:0] sub, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      bit ok;
      u_fieldbus_host.access(wr, idx, sub, wd, rd, err, ok);
      if (!ok) begin
         mismatches++;
         $display("mismatch parDone expected 1 seen 0");
         stop_test();
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] rd;
      logic        err;
      par(1'b1, idx, SUB_STATUS, d, rd, err);
      check("write error", err, 1'b0);
   endtask
   task automatic rd_check(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] rd;
      logic        err;
      par(1'b0, idx, SUB_STATUS, 32'h0, rd, err);
      check("parameter", rd, exp);
   endtask
   task automatic rec_check(input int ch);
      logic [31:0] rd;
      logic        err;
      rd_check(REC_IDX[ch], {28'h0, pri[ch] >= PRI_CRIT_MIN,
         pri[ch] >= PRI_NOTICE_MIN, eUnack[ch], eAct[ch]});
      par(1'b0, REC_IDX[ch], SUB_TIME, 32'h0, rd, err);
      check("record time", rd, eTime[ch]);
      par(1'b0, REC_IDX[ch], SUB_VALUE, 32'h0, rd, err);
      check("record value", rd, eVal[ch]);
      par(1'b1, REC_IDX[ch], SUB_TIME, rnd(), rd, err);
      check("record write refused", err, 1'b1);
   endtask
   task automatic set_pri(input int ch, input logic [3:0] p);
      logic [31:0] rd;
      logic        err;
      bit          ok;
      int          rch;
      rch     = (ch == 1) ? 2 : ch;
      pri[ch] = p;
      // read of the neighbour or of itself right behind the write
      u_fieldbus_host.write_read(PRI_IDX[ch], {28'h0, p}, PRI_IDX[rch], rd,
         err, ok);
      check("priority pair", rd, {28'h0, pri[rch]});
      check("pair answered", {ok, err}, 2'b10);
      if (p == PRI_OFF)
         eAct[ch] = 1'b0;
      rd_check(PRI_IDX[ch], {28'h0, p});
      check("alarmActive", alarmActive, eAct);
   endtask
   task automatic ack(input int ch);
      logic err;
      bit   ok;
      u_fieldbus_host.acknowledge(ch, err, ok);
      eUnack[ch] = 1'b0;
      check("ack answered", {ok, err}, 2'b10);
      check("alarmUnacked", alarmUnacked, eUnack);
   endtask
   task automatic step(input logic [31:0] v);
      logic [3:0]  ePulse, eCrit;
      logic [31:0] t;
      ePulse = 4'h0;
      eCrit  = 4'h0;
      t      = rnd();
      @(negedge ref_clk);
      procValue = v;
      timeNow   = t;
      procValid = 1'b1;
      for (int ch = 0; ch < 4; ch++) begin
         if (pri[ch] == PRI_OFF)
            eAct[ch] = 1'b0;
         else if (!eAct[ch] && beyond(ch, v)) begin
            eAct[ch]   = 1'b1;
            eTime[ch]  = t;
            eVal[ch]   = v;
            eUnack[ch] = !ackOpt[ACKOPT_POS[ch]];
            ePulse[ch] = pri[ch] >= PRI_NOTICE_MIN;
            eCrit[ch]  = pri[ch] >= PRI_CRIT_MIN;
         end else if (eAct[ch] && backIn(ch, v))
            eAct[ch] = 1'b0;
      end
      @(negedge ref_clk);
      procValid = 1'b0;
      procValue = ~v;
      check("alarmActive", alarmActive, eAct);
      check("alarmUnacked", alarmUnacked, eUnack);
      check("alertPulse", alertPulse, ePulse);
      check("alertCritical", alertCritical, eCrit);
   endtask

   initial begin
      logic [31:0] rd, r, v;
      logic        err;
      logic [3:0]  p;
      ref_clk    = 1'b0;
      rst_n      = 1'b0;
      procValue  = 32'h0;
      procValid  = 1'b0;
      timeNow    = 32'h0;
      lfsr       = 32'h22af;
      mismatches = 0;
      n_tests    = 0;
      eAct       = 4'h0;
      eUnack     = 4'h0;
      ackOpt     = RST_ACK_OPTION;
      hyst       = RST_HYSTERESIS;
      for (int i = 0; i < 4; i++) begin
         lim[i]   = (i < 2) ? RST_UPPER_LIMIT : RST_LOWER_LIMIT;
         pri[i]   = RST_PRIORITY;
         eTime[i] = 32'h0;
         eVal[i]  = 32'h0;
      end
      repeat (10) @(negedge ref_clk);
      rst_n = 1'b1;
      for (int i = 0; i < 4; i++) begin
         rd_check(LIM_IDX[i], lim[i]);
         rd_check(PRI_IDX[i], 32'h0);
         rec_check(i);
      end
      rd_check(IDX_ALARM_HYSTERESIS, hyst);
      rd_check(IDX_ACK_OPTION, 32'h0);
      par(1'b0, 8'h40, SUB_STATUS, 32'h0, rd, err);
      check("unmapped error", err, 1'b1);
      par(1'b0, IDX_UPPER_ALARM_RECORD, 2'h3, 32'h0, rd, err);
      check("bad sub error", err, 1'b1);
      step(32'h80000000);
      hyst = 32'h32;
      wr(IDX_ALARM_HYSTERESIS, hyst);
      lim = '{32'h3e8, 32'h1f4, 32'hfffffe0c, 32'hfffffc18};
      for (int i = 0; i < 4; i++) begin
         wr(LIM_IDX[i], lim[i]);
         rd_check(LIM_IDX[i], lim[i]);
      end
      set_pri(0, 4'hf);
      set_pri(1, 4'h3);
      set_pri(2, 4'h1);
      set_pri(3, 4'h8);
      step(32'h3e8);
      step(32'h3e9);
      step(32'h3b7);
      step(32'h3b5);
      rec_check(0);
      ack(0);
      ack(1);
      ackOpt = 8'h3c;
      wr(IDX_ACK_OPTION, 32'h3c);
      step(32'hfffff830);
      set_pri(3, PRI_OFF);
      repeat (80) begin
         r = rnd();
         case (r[2:0])
            3'h0: begin
               p = r[7:4];
               if (p == PRI_RESERVED)
                  p = PRI_NOTICE_MIN;
               set_pri(int'(r[9:8]), p);
            end
            3'h1: ack(int'(r[9:8]));
            3'h2: begin
               ackOpt = r[15:8];
               wr(IDX_ACK_OPTION, {24'h0, ackOpt});
            end
            3'h3: rec_check(int'(r[9:8]));
            default: begin
               v = {20'h0, r[27:16]} % 32'hbb8 - 32'h5dc;
               step(v);
            end
         endcase
      end
      stop_test();
   end
endmodule
`default_nettype wire
